// File: scg_pkg.sv
// Shared constants and types of the system clock generator.
// Assumes one 50 MHz system clock; oscillators are modelled as tick enables.
package scg_pkg;

    ////////////////////////////////////////////////////////////////////////////////////
    // Rates
    localparam int CLK_HZ = 50_000_000; // System clock rate
    localparam int MAIN_OSC_HZ = 5_000_000; // Crystal main oscillator rate
    localparam int SUB_OSC_HZ = 32_768; // Subsystem oscillator rate
    localparam int MAIN_DIV = CLK_HZ / MAIN_OSC_HZ; // System clocks per main tick
    localparam int SUB_DIV = CLK_HZ / SUB_OSC_HZ; // System clocks per sub tick

    ////////////////////////////////////////////////////////////////////////////////////
    // Device register map
    localparam logic [15:0] ADDR_SUBOSC = 16'hFFF0; // suboscillator_mode
    localparam logic [15:0] ADDR_CSS = 16'hFFF2; // subclock_control_reg
    localparam logic [15:0] ADDR_PCC = 16'hFFFB; // processor_clock_control
    localparam logic [2:0] PCC_MCC_BIT = 3'h7; // main_osc_stop
    localparam logic [2:0] PCC_DIV_BIT = 3'h1; // main_divide_select
    localparam logic [2:0] SUBOSCILLATOR_MODE_FRC_BIT = 3'h1; // feedback_resistor_off
    localparam logic [2:0] SUBOSCILLATOR_MODE_SCC_BIT = 3'h0; // sub_osc_stop
    localparam logic [2:0] CSS_SEL_BIT = 3'h4; // sub_clock_select
    localparam logic [2:0] CSS_CLS_BIT = 3'h5; // cpu_on_sub_flag, read only
    localparam logic [7:0] PCC_RESET = 8'h02; // Divided main clock, oscillator on
    localparam logic [7:0] SUBOSCILLATOR_MODE_RESET = 8'h00; // Sub oscillator and resistor on
    localparam logic [7:0] CSS_RESET = 8'h00; // Main clock selected
    localparam logic [7:0] PCC_WMASK = 8'h82; // Writable bits
    localparam logic [7:0] SUBOSCILLATOR_MODE_WMASK = 8'h03; // Writable bits
    localparam logic [7:0] CSS_WMASK = 8'h10; // Writable bits
    localparam logic [1:0] MAIN_QUARTER_LAST = 2'h3; // Last phase of main/4
    localparam logic [7:0] BYTE_ZERO = 8'h00; // Idle read data

    ////////////////////////////////////////////////////////////////////////////////////
    // Controller register map (user port of the CPU end)
    localparam logic [3:0] HOST_WR_PCC = 4'h0; // Byte write to processor_clock_control
    localparam logic [3:0] HOST_WR_SUBOSC = 4'h1; // Byte write to suboscillator_mode
    localparam logic [3:0] HOST_WR_CSS = 4'h2; // Byte write to subclock_control_reg
    localparam logic [3:0] HOST_BIT_OP = 4'h3; // [1:0] target, [4:2] bit, [5] value
    localparam logic [3:0] HOST_FETCH = 4'h4; // Write: [1:0] target to read back
    localparam logic [3:0] HOST_FETCHED = 4'h5; // Read: last fetched byte
    localparam logic [3:0] HOST_STANDBY = 4'h6; // Write: [0] halt, [1] stop, [2] wake
    localparam logic [3:0] HOST_STATUS = 4'h7; // Read: link status, [7] refused
    localparam logic [1:0] TGT_PCC = 2'h0; // Target codes
    localparam logic [1:0] TGT_SUBOSC = 2'h1;
    localparam logic [1:0] TGT_CSS = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {
        SCG_SRC_MAIN = 1'b0, // Main clock, whole or divided by four, drives the CPU
        SCG_SRC_SUB = 1'b1 // Subsystem clock drives the CPU
    } scg_src_t;

    typedef enum logic [1:0] {
        SCG_RUN = 2'b00, // CPU clock runs
        SCG_HALT = 2'b01, // CPU clock gated, oscillators run
        SCG_STOP = 2'b10 // Main oscillator stopped too
    } scg_mode_t;

endpackage

// File: scg_link_if.sv
// Link between the clock generator and the CPU core that programs it.
// Both ends run on the same clock; nothing here is registered.
`timescale 1ns/1ps
`default_nettype none
interface scg_link_if;
    logic [15:0] addr; // Register address
    logic [7:0] wdata; // Byte write data
    logic wr; // Byte write strobe
    logic bit_wr; // Single-bit write strobe
    logic [2:0] bit_sel; // Bit index of a bit write
    logic bit_val; // Value of a bit write
    logic rd; // Read strobe
    logic [7:0] rdata; // Read data, valid the cycle after rd
    logic halt_req; // Enter HALT
    logic stop_req; // Enter STOP
    logic wake; // Leave standby
    logic cpu_tick; // CPU clock enable
    logic instr_tick; // One per least instruction time
    logic periph_tick; // Main clock enable for peripherals
    logic sub_tick; // Subsystem clock enable
    logic cpu_on_sub; // CPU runs from subsystem clock
    logic main_running; // Main oscillator running
    logic sub_running; // Sub oscillator running
    logic fb_res_off; // Sub feedback resistor disconnected
    logic in_halt; // HALT active
    logic in_stop; // STOP active

    modport dev (
        input addr, wdata, wr, bit_wr, bit_sel, bit_val, rd, halt_req, stop_req, wake,
        output rdata, cpu_tick, instr_tick, periph_tick, sub_tick, cpu_on_sub,
        output main_running, sub_running, fb_res_off, in_halt, in_stop
    );
    modport cpu (
        output addr, wdata, wr, bit_wr, bit_sel, bit_val, rd, halt_req, stop_req, wake,
        input rdata, cpu_tick, instr_tick, periph_tick, sub_tick, cpu_on_sub,
        input main_running, sub_running, fb_res_off, in_halt, in_stop
    );
endinterface
`default_nettype wire

// File: scg_osc_div.sv
// Oscillator model: one tick every DIV system clocks while enabled.
// Assumes the enable comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module scg_osc_div #(
    parameter int DIV = 10 // System clocks per oscillator period
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic en, // Oscillator runs
    output logic tick // One-cycle pulse per period
);
    localparam int W = $clog2(DIV); // Counter width

    initial begin
        if (DIV < 2) begin
            $error("scg_osc_div: DIV must be at least 2");
        end
    end

    typedef struct packed {
        logic [W-1:0] count; // Position in the period
        logic tick; // Registered tick
    } scg_div_state_t;

    scg_div_state_t s; // Present state
    scg_div_state_t next_s; // Next state

    ////////////////////////////////////////////////////////////////////////////////////
    // Count while running; a stopped oscillator restarts from a full period
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!en) begin
            next_s.count = '0;
        end else if (s.count == W'(DIV - 1)) begin
            next_s.count = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.count = s.count + W'(1);
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

// File: scg_clock_gen.sv
// Clock generator end: control registers, oscillator gating, CPU clock select
// and divide, standby modes. Clocks are delivered as one-cycle enables.
// Assumes the CPU end drives the link from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - main oscillator stops on STOP or control bit
// - sub oscillator stopped only by its mode register
// - processor clock control resets to 02H
// - bit 7 set stops main oscillator
// - CPU clock main, main/4 or sub/2
// - software stops main only when on sub
// - software writes zero to reserved clock-control bits
// - instruction time is two CPU clocks
// - suboscillator mode resets to 00H
// - bit 1 disconnects sub feedback resistor
// - bit 0 set stops sub oscillator
// - resistor off only when subclock unused
// - software writes zero to suboscillator bits 2-7
// - registers take bit and byte writes
// - subclock control bit 4 picks CPU source
// - bit 5 reads back actual CPU source
// - main oscillator stopped while reset held
// - on subclock HALT allowed, STOP refused
module scg_clock_gen
    import scg_pkg::*;
#(
    parameter int MAIN_PERIOD = MAIN_DIV, // System clocks per main oscillator tick
    parameter int SUB_PERIOD = SUB_DIV // System clocks per sub oscillator tick
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst, // Asynchronous reset, active high
    scg_link_if.dev link // CPU side of the generator
);
    initial begin
        if (MAIN_PERIOD < 2 || SUB_PERIOD < 2) begin
            $error("scg_clock_gen: oscillator periods must be at least 2");
        end
    end

    typedef struct packed {
        logic main_osc_stop; // Main oscillator gate
        logic main_divide_select; // Main clock divided by four
        logic feedback_resistor_off; // Sub feedback resistor off
        logic sub_osc_stop; // Sub oscillator gate
        logic sub_clock_select; // Requested CPU source
        scg_src_t active_src; // Source actually driving the CPU
        scg_mode_t mode; // Standby state
        logic [1:0] phase; // CPU divide phase
        logic half; // Second CPU clock of an instruction slot
        logic [7:0] rdata; // Read data
        logic cpu_tick; // Registered outputs
        logic instr_tick;
        logic periph_tick;
        logic sub_tick;
        logic main_running;
        logic sub_running;
    } scg_gen_state_t;

    scg_gen_state_t s; // Present state
    scg_gen_state_t next_s; // Next state
    logic main_run; // Main oscillator enable
    logic main_tick; // Main oscillator tick
    logic sub_tick; // Sub oscillator tick
    logic [7:0] pcc_byte; // processor_clock_control as read
    logic [7:0] suboscillator_mode_byte; // suboscillator_mode as read
    logic [7:0] css_byte; // subclock_control_reg as read
    logic [7:0] pcc_new; // After this cycle's write
    logic [7:0] suboscillator_mode_new;
    logic [7:0] css_new;
    logic src_tick; // Tick of the active source

    // Byte or bit update of one register, write mask applied
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] mask,
                                         input logic hit);
        logic [7:0] upd;
        upd = cur;
        if (hit && link.wr) begin
            upd = link.wdata;
        end else if (hit && link.bit_wr) begin
            upd[link.bit_sel] = link.bit_val;
        end
        return upd & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // Oscillators
    // Reset clears main_osc_stop but holds the divider in reset, so no tick while held
    assign main_run = !s.main_osc_stop && (s.mode != SCG_STOP);

    scg_osc_div #(.DIV(MAIN_PERIOD)) main_osc (
        .clk(clk),
        .rst(rst),
        .en(main_run),
        .tick(main_tick)
    );

    // Only its own gate bit stops it; STOP leaves it running for the watch logic
    scg_osc_div #(.DIV(SUB_PERIOD)) sub_osc (
        .clk(clk),
        .rst(rst),
        .en(!s.sub_osc_stop),
        .tick(sub_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Register views; reserved bits read as zero
    always_comb begin
        pcc_byte = BYTE_ZERO;
        pcc_byte[PCC_MCC_BIT] = s.main_osc_stop;
        pcc_byte[PCC_DIV_BIT] = s.main_divide_select;
        suboscillator_mode_byte = BYTE_ZERO;
        suboscillator_mode_byte[SUBOSCILLATOR_MODE_FRC_BIT] = s.feedback_resistor_off;
        suboscillator_mode_byte[SUBOSCILLATOR_MODE_SCC_BIT] = s.sub_osc_stop;
        css_byte = BYTE_ZERO;
        css_byte[CSS_SEL_BIT] = s.sub_clock_select;
        css_byte[CSS_CLS_BIT] = s.active_src;
        pcc_new = merge(pcc_byte, PCC_WMASK, link.addr == ADDR_PCC);
        suboscillator_mode_new = merge(suboscillator_mode_byte, SUBOSCILLATOR_MODE_WMASK, link.addr == ADDR_SUBOSC);
        css_new = merge(css_byte, CSS_WMASK, link.addr == ADDR_CSS); // Status bit masked off
        src_tick = (s.active_src == SCG_SRC_SUB) ? sub_tick : main_tick;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        // Register writes
        next_s.main_osc_stop = pcc_new[PCC_MCC_BIT];
        next_s.main_divide_select = pcc_new[PCC_DIV_BIT];
        next_s.feedback_resistor_off = suboscillator_mode_new[SUBOSCILLATOR_MODE_FRC_BIT];
        next_s.sub_osc_stop = suboscillator_mode_new[SUBOSCILLATOR_MODE_SCC_BIT];
        next_s.sub_clock_select = css_new[CSS_SEL_BIT];
        // Reads answer next cycle only; unmapped addresses read zero
        next_s.rdata = BYTE_ZERO;
        if (link.rd) begin
            unique case (link.addr)
                ADDR_PCC: next_s.rdata = pcc_byte;
                ADDR_SUBOSC: next_s.rdata = suboscillator_mode_byte;
                ADDR_CSS: next_s.rdata = css_byte;
                default: next_s.rdata = BYTE_ZERO;
            endcase
        end
        // Source switch waits for a tick of the new source so that no short
        // CPU period is produced; if the new oscillator is stopped it never
        // happens and the CPU clock stays stopped while active_src keeps the old source
        if (s.sub_clock_select != s.active_src) begin
            if ((s.sub_clock_select ? sub_tick : main_tick)) begin
                next_s.active_src = scg_src_t'(s.sub_clock_select);
                next_s.phase = 2'h0;
                next_s.half = 1'b0;
            end
        end
        // Standby
        unique case (s.mode)
            SCG_RUN: begin
                if (link.stop_req && s.active_src == SCG_SRC_MAIN) begin
                    next_s.mode = SCG_STOP;
                end else if (link.halt_req) begin
                    next_s.mode = SCG_HALT;
                end
            end
            SCG_HALT, SCG_STOP: begin
                if (link.wake) begin
                    next_s.mode = SCG_RUN;
                end
            end
            default: next_s.mode = SCG_RUN;
        endcase
        // CPU clock divide
        next_s.cpu_tick = 1'b0;
        next_s.instr_tick = 1'b0;
        if (s.sub_clock_select == s.active_src && src_tick) begin
            next_s.phase = s.phase + 2'h1;
            if (s.active_src == SCG_SRC_SUB) begin
                next_s.cpu_tick = s.phase[0];
            end else if (s.main_divide_select) begin
                next_s.cpu_tick = (s.phase == MAIN_QUARTER_LAST);
            end else begin
                next_s.cpu_tick = 1'b1;
            end
            // Standby gates the CPU clock from its entry cycle; the divider keeps counting
            if (next_s.mode != SCG_RUN) begin
                next_s.cpu_tick = 1'b0;
            end
        end
        // Instruction slot of two CPU clocks
        if (next_s.cpu_tick) begin
            next_s.half = !s.half;
            next_s.instr_tick = s.half;
        end
        next_s.periph_tick = main_tick;
        next_s.sub_tick = sub_tick;
        next_s.main_running = main_run;
        next_s.sub_running = !s.sub_osc_stop;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // State register; reset values come from the register reset bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.main_osc_stop <= PCC_RESET[PCC_MCC_BIT];
            s.main_divide_select <= PCC_RESET[PCC_DIV_BIT];
            s.feedback_resistor_off <= SUBOSCILLATOR_MODE_RESET[SUBOSCILLATOR_MODE_FRC_BIT];
            s.sub_osc_stop <= SUBOSCILLATOR_MODE_RESET[SUBOSCILLATOR_MODE_SCC_BIT];
            s.sub_clock_select <= CSS_RESET[CSS_SEL_BIT];
            s.active_src <= SCG_SRC_MAIN;
            s.mode <= SCG_RUN;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops; in_halt and in_stop decoded from the mode register
    assign link.rdata = s.rdata;
    assign link.cpu_tick = s.cpu_tick;
    assign link.instr_tick = s.instr_tick;
    assign link.periph_tick = s.periph_tick;
    assign link.sub_tick = s.sub_tick;
    assign link.cpu_on_sub = s.active_src;
    assign link.main_running = s.main_running;
    assign link.sub_running = s.sub_running;
    assign link.fb_res_off = s.feedback_resistor_off;
    assign link.in_halt = (s.mode == SCG_HALT);
    assign link.in_stop = (s.mode == SCG_STOP);
endmodule
`default_nettype wire

// File: scg_cpu_ctrl.sv
// CPU end: turns software orders on a plain register port into link accesses,
// keeping reserved bits zero and refusing unsafe oscillator settings.
// Assumes the generator answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module scg_cpu_ctrl
    import scg_pkg::*;
#(
    parameter bit SUB_USED = 1'b1 // Board fits a subsystem crystal
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [3:0] addr, // Controller register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, one cycle after rd
    scg_link_if.cpu link // Link to the generator
);
    typedef struct packed {
        logic [15:0] addr; // Link outputs
        logic [7:0] wdata;
        logic wr;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
        logic rd;
        logic halt_req;
        logic stop_req;
        logic wake;
        logic fetch_wait; // Read answer due this cycle
        logic [7:0] fetched; // Last byte read back
        logic refused; // Sticky: an order was dropped
        logic [7:0] rdata; // User read data
    } scg_cpu_state_t;

    scg_cpu_state_t s; // Present state
    scg_cpu_state_t next_s; // Next state
    logic [15:0] tgt_addr; // Link address of a target code
    logic [1:0] tgt; // Target code of this order
    logic [7:0] safe; // Byte after the safety masks
    logic drop; // Order refused

    // Target code to device address
    always_comb begin
        tgt = (addr == HOST_BIT_OP || addr == HOST_FETCH) ? wdata[1:0] : addr[1:0];
        unique case (tgt)
            TGT_PCC: tgt_addr = ADDR_PCC;
            TGT_SUBOSC: tgt_addr = ADDR_SUBOSC;
            default: tgt_addr = ADDR_CSS;
        endcase
        // Build the byte the order would leave in place
        safe = wdata;
        drop = 1'b0;
        if (addr == HOST_BIT_OP) begin
            safe = BYTE_ZERO;
            safe[wdata[4:2]] = wdata[5];
        end
        unique case (tgt)
            TGT_PCC: begin
                safe = safe & PCC_WMASK;
                if (safe[PCC_MCC_BIT] && !link.cpu_on_sub) begin
                    safe[PCC_MCC_BIT] = 1'b0;
                    drop = 1'b1;
                end
            end
            TGT_SUBOSC: begin
                safe = safe & SUBOSCILLATOR_MODE_WMASK;
                if (safe[SUBOSCILLATOR_MODE_FRC_BIT] && SUB_USED) begin
                    safe[SUBOSCILLATOR_MODE_FRC_BIT] = 1'b0;
                    drop = 1'b1;
                end
            end
            default: safe = safe & CSS_WMASK;
        endcase
        // A bit order setting a reserved or unsafe bit to one is dropped whole
        if (addr == HOST_BIT_OP && wdata[5] && !safe[wdata[4:2]]) begin
            drop = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state: one order per cycle; only a standby order can raise more than one strobe
    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.bit_wr = 1'b0;
        next_s.rd = 1'b0;
        next_s.halt_req = 1'b0;
        next_s.stop_req = 1'b0;
        next_s.wake = 1'b0;
        next_s.fetch_wait = s.rd;
        next_s.rdata = BYTE_ZERO;
        if (s.fetch_wait) begin
            next_s.fetched = link.rdata;
        end
        if (wr) begin
            next_s.addr = tgt_addr;
            unique case (addr)
                HOST_WR_PCC, HOST_WR_SUBOSC, HOST_WR_CSS: begin
                    next_s.wr = 1'b1;
                    next_s.wdata = safe;
                end
                HOST_BIT_OP: begin
                    next_s.bit_wr = !drop || !wdata[5];
                    next_s.bit_sel = wdata[4:2];
                    next_s.bit_val = wdata[5];
                end
                HOST_FETCH: next_s.rd = 1'b1;
                HOST_STANDBY: begin
                    next_s.halt_req = wdata[0];
                    next_s.stop_req = wdata[1];
                    next_s.wake = wdata[2];
                end
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                HOST_FETCHED: next_s.rdata = s.fetched;
                HOST_STATUS: next_s.rdata = {s.refused, 1'b0, link.in_stop, link.in_halt,
                                             link.fb_res_off, link.sub_running,
                                             link.main_running, link.cpu_on_sub};
                default: next_s.rdata = BYTE_ZERO;
            endcase
            if (addr == HOST_STATUS) begin
                next_s.refused = 1'b0;
            end
        end
        // A new refusal wins over the clear by a status read
        if (wr && drop && (addr <= HOST_BIT_OP)) begin
            next_s.refused = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops
    assign rdata = s.rdata;
    assign link.addr = s.addr;
    assign link.wdata = s.wdata;
    assign link.wr = s.wr;
    assign link.bit_wr = s.bit_wr;
    assign link.bit_sel = s.bit_sel;
    assign link.bit_val = s.bit_val;
    assign link.rd = s.rd;
    assign link.halt_req = s.halt_req;
    assign link.stop_req = s.stop_req;
    assign link.wake = s.wake;
endmodule
`default_nettype wire

// File: scg_link_sva.sv
// Checker of the link between the clock generator and its CPU end.
// Assumes one clock domain; every link signal except in_halt and in_stop, decoded from the mode register, comes from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module scg_link_sva
    import scg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [15:0] addr, // Device address
    input wire logic [7:0] wdata, // Byte write data
    input wire logic wr, // Byte write strobe
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata, // Read data
    input wire logic stop_req, // Stop request
    input wire logic cpu_tick, // CPU clock enable
    input wire logic instr_tick, // Instruction enable
    input wire logic cpu_on_sub, // CPU on subclock
    input wire logic main_running, // Main oscillator runs
    input wire logic sub_running, // Sub oscillator runs
    input wire logic in_halt, // Halt active
    input wire logic in_stop // Stop active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    //////////////////////////////////////////
    property p_rd_idle; !rd |=> rdata == BYTE_ZERO; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_instr; instr_tick |-> cpu_tick ##1 !instr_tick[*5]; endproperty
    a_instr: assert property (p_instr) else $error("instruction tick wrong");
    property p_gap; cpu_tick |=> !cpu_tick ##1 !cpu_tick; endproperty
    a_gap: assert property (p_gap) else $error("cpu ticks too close");
    property p_still; in_halt || in_stop |-> !cpu_tick; endproperty
    a_still: assert property (p_still) else $error("cpu tick in standby");
    property p_nostop; cpu_on_sub && stop_req |=> !in_stop; endproperty
    a_nostop: assert property (p_nostop) else $error("stop taken on subclock");
    property p_main_off; wr && addr == ADDR_PCC && wdata[7] |-> ##[1:3] !main_running; endproperty
    a_main_off: assert property (p_main_off) else $error("main osc not stopped");
    property p_sub_off; wr && addr == ADDR_SUBOSC && wdata[0] |-> ##[1:3] !sub_running; endproperty
    a_sub_off: assert property (p_sub_off) else $error("sub osc not stopped");
    property p_stop_main; $rose(in_stop) |-> ##[0:2] !main_running; endproperty
    a_stop_main: assert property (p_stop_main) else $error("main runs in stop");
    // Main scenarios reached
    c_sub: cover property ($rose(cpu_on_sub));
    c_halt: cover property ($rose(in_halt));
    c_stop: cover property ($rose(in_stop));
endmodule
`default_nettype wire

// File: tb.sv
// Testbench: both ends joined by the link; software orders on the controller port.
// Assumes short oscillator periods of 3 and 8 system clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0; // System clock
    logic rst = 1'b1; // Reset
    logic [3:0] addr = 4'h0; // Controller address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic [7:0] rdata; // Read data
    int bad_count = 0; // Mismatches
    int total_checks = 0; // Comparisons
    int cyc = 0; // Hang guard
    scg_link_if link ();
    scg_clock_gen #(.MAIN_PERIOD(3), .SUB_PERIOD(8)) scg_clock_gen_i (.clk(clk), .rst(rst),
        .link(link));
    scg_cpu_ctrl scg_cpu_ctrl_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .link(link));
    scg_link_sva scg_link_sva_i (.clk(clk), .rst(rst), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .stop_req(link.stop_req),
        .cpu_tick(link.cpu_tick), .instr_tick(link.instr_tick), .cpu_on_sub(link.cpu_on_sub),
        .main_running(link.main_running), .sub_running(link.sub_running),
        .in_halt(link.in_halt), .in_stop(link.in_stop));
    //////////////////////////////////////////
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // Read slot: data stand only in the cycle after the strobe
    task automatic look(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & mask, exp);
    endtask
    // Device register read back through the fetch slot
    task automatic fetch(input logic [7:0] tgt, input logic [7:0] exp);
        put(4'h4, tgt);
        repeat (3) @(posedge clk);
        look(4'h5, 8'hFF, exp);
    endtask
    task automatic t_reset();
        fetch(8'h00, 8'h02);
        fetch(8'h01, 8'h00);
        look(4'h7, 8'hFF, 8'h06);
    endtask
    task automatic t_bit_and_refuse();
        put(4'h3, 8'h04); // Bit op: PROCESSOR_CLOCK_CONTROL bit 1 to 0
        fetch(8'h00, 8'h00);
        put(4'h0, 8'hFE); // Stop main while on main clock
        fetch(8'h00, 8'h02);
        look(4'h7, 8'h83, 8'h82);
    endtask
    task automatic t_sub();
        put(4'h2, 8'h30); // Bit 5 is read only
        repeat (60) @(posedge clk);
        fetch(8'h02, 8'h30);
        put(4'h0, 8'h80);
        repeat (6) @(posedge clk);
        look(4'h7, 8'h03, 8'h01);
        put(4'h6, 8'h02); // Stop is refused on subclock
        put(4'h6, 8'h01);
        look(4'h7, 8'h30, 8'h10);
        put(4'h6, 8'h04);
        put(4'h0, 8'h00);
        put(4'h2, 8'h00);
        repeat (60) @(posedge clk);
        look(4'h7, 8'h03, 8'h02);
    endtask
    task automatic t_osc_stops();
        put(4'h1, 8'hFD);
        repeat (6) @(posedge clk);
        look(4'h7, 8'h04, 8'h00);
        put(4'h1, 8'h02); // Resistor off with a subclock fitted
        look(4'h7, 8'h88, 8'h80);
        put(4'h6, 8'h02);
        repeat (4) @(posedge clk);
        look(4'h7, 8'h22, 8'h20);
        put(4'h6, 8'h04);
    endtask
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    // Cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        chk(link.main_running, 8'h00);
        rst <= 1'b0;
        t_reset();
        t_bit_and_refuse();
        t_sub();
        t_osc_stops();
        summarize();
    end
endmodule
`default_nettype wire
